// >>> design/ecs_config_source.sv
// Configuration source: EEPROM loader, attribute registers and descriptor RAM behind APB.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module ecs_config_source #(
  parameter int RAM_WORDS = ecs_pkg::RAM_WORDS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eeprom_present,
  output logic ee_rd_req,
  output logic [7:0] ee_rd_addr,
  input wire logic ee_rd_ack,
  input wire logic [7:0] ee_rd_data,
  input wire logic [6:0] desc_raddr,
  output logic [31:0] desc_rdata,
  output ecs_pkg::ecs_cfg_t cfg
);

  // ==========================================================================
  // State.
  ecs_pkg::ecs_state_t ld_state;
  ecs_pkg::ecs_state_t next_ld_state;
  logic [3:0] ld_idx;
  logic [31:0] hardware_config_reg, led_cfg, wake, addr_hi, addr_lo;
  logic [31:0] hs_len, fs_len, str_a, str_b, flag_reg;
  logic [6:0] ram_addr;
  logic attr_seen;
  logic [31:0] ram [RAM_WORDS];

  // Bus decode; the slave answers in the access cycle with no wait state.
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire hit = (paddr[1:0] == 2'b00) && (paddr <= ecs_pkg::OFS_RAM_DATA);
  wire wr = acc & pwrite & hit;
  wire eeprom_emulation_enable = hardware_config_reg[ecs_pkg::HW_EEM_BIT];
  wire ee_mode = eeprom_present & ~eeprom_emulation_enable;
  wire ld_busy = (ld_state != ecs_pkg::ECS_DONE) && (ld_state != ecs_pkg::ECS_IDLE);
  wire wr_flag = wr && (paddr == ecs_pkg::OFS_FLAG) && !ee_mode;
  wire wr_ram = wr && (paddr == ecs_pkg::OFS_RAM_DATA);
  wire wr_attr = wr && (paddr == ecs_pkg::OFS_HS_LEN || paddr == ecs_pkg::OFS_FS_LEN ||
                        paddr == ecs_pkg::OFS_STR_A || paddr == ecs_pkg::OFS_STR_B);
  wire ee_take = (ld_state == ecs_pkg::ECS_WAIT) & ee_rd_ack;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  // Rounds a descriptor length up to the next word boundary.
  function automatic logic [9:0] al4(input logic [7:0] len);
    logic [9:0] s;
    s = {2'b00, len} + 10'h003;
    al4 = {s[9:2], 2'b00};
  endfunction

  // Picks one byte lane of a word.
  function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] sel);
    lane = 8'(w >> {sel, 3'b000});
  endfunction

  // Maps a load step to its EEPROM byte address.
  function automatic logic [7:0] ee_item(input logic [3:0] i);
    case (i)
      4'h6: ee_item = ecs_pkg::EE_BOOST;
      4'h7: ee_item = ecs_pkg::EE_LED;
      4'h8: ee_item = ecs_pkg::EE_WAKE_LO;
      4'h9: ee_item = ecs_pkg::EE_WAKE_HI;
      4'ha: ee_item = ecs_pkg::EE_PME;
      4'hb: ee_item = ecs_pkg::EE_CFG_FLAGS;
      default: ee_item = ecs_pkg::EE_ADDR_BASE + {4'h0, i};
    endcase
  endfunction

  // Descriptor layout in RAM: language, five strings, device and configuration per speed.
  wire [9:0] hs_cfg_base = al4(str_a[7:0]) + al4(str_a[15:8]) + al4(str_a[23:16]) +
                           al4(str_a[31:24]) + al4(str_b[7:0]) + al4(str_b[15:8]) +
                           al4(hs_len[7:0]);
  wire [9:0] fs_cfg_base = hs_cfg_base + al4(hs_len[15:8]) + al4(fs_len[7:0]);
  wire [9:0] high_speed_length_reg_at = hs_cfg_base + ecs_pkg::CFG_ATTR_OFS;
  wire [9:0] full_speed_length_reg_at = fs_cfg_base + ecs_pkg::CFG_ATTR_OFS;
  wire high_speed_length_reg_hit = (hs_len[15:8] != 8'h00) && (high_speed_length_reg_at[8:2] == ram_addr);
  wire full_speed_length_reg_hit = (fs_len[15:8] != 8'h00) && (full_speed_length_reg_at[8:2] == ram_addr);
  wire [7:0] attr_byte = high_speed_length_reg_hit ? lane(pwdata, high_speed_length_reg_at[1:0]) :
                                       lane(pwdata, full_speed_length_reg_at[1:0]);
  wire flags_from_ram = wr_ram & attr_seen & (high_speed_length_reg_hit | full_speed_length_reg_hit);

  // Loader sequencing; it never addresses the free host area at the image tail.
  always_comb begin
    next_ld_state = ld_state;
    case (ld_state)
      ecs_pkg::ECS_IDLE: begin
        if (ee_mode) begin
          next_ld_state = ecs_pkg::ECS_REQ;
        end else begin
          next_ld_state = ecs_pkg::ECS_IDLE;
        end
      end
      ecs_pkg::ECS_REQ: next_ld_state = ecs_pkg::ECS_WAIT;
      ecs_pkg::ECS_WAIT: begin
        if (ee_rd_ack) begin
          next_ld_state = (ld_idx == ecs_pkg::EE_ITEMS - 4'h1) ? ecs_pkg::ECS_DONE :
                                                                 ecs_pkg::ECS_REQ;
        end
      end
      ecs_pkg::ECS_DONE: next_ld_state = ecs_pkg::ECS_DONE;
      default: next_ld_state = ecs_pkg::ECS_IDLE;
    endcase
  end

  // Loader state and step counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_state <= ecs_pkg::ECS_IDLE;
      ld_idx <= 4'h0;
    end else begin
      ld_state <= next_ld_state;
      if (ee_take) begin
        ld_idx <= ld_idx + 4'h1;
      end
    end
  end

  // EEPROM request holds address until acknowledged.
  assign ee_rd_req = (ld_state == ecs_pkg::ECS_WAIT);
  assign ee_rd_addr = ee_item(ld_idx);

  // Control registers written by software or by the loader.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hardware_config_reg <= ecs_pkg::RESET_WORD;
      led_cfg <= ecs_pkg::RESET_WORD;
      wake <= ecs_pkg::RESET_WORD;
      addr_hi <= ecs_pkg::RESET_WORD;
      addr_lo <= ecs_pkg::RESET_WORD;
    end else if (ee_take) begin
      case (ld_idx)
        4'h0: addr_lo[7:0] <= ee_rd_data;
        4'h1: addr_lo[15:8] <= ee_rd_data;
        4'h2: addr_lo[23:16] <= ee_rd_data;
        4'h3: addr_lo[31:24] <= ee_rd_data;
        4'h4: addr_hi[7:0] <= ee_rd_data;
        4'h5: addr_hi[15:8] <= ee_rd_data;
        4'h6: hardware_config_reg[ecs_pkg::HW_BOOST_LSB +: 2] <= ee_rd_data[1:0];
        4'h7: led_cfg[0] <= ee_rd_data[0];
        4'h8: wake[7:0] <= ee_rd_data;
        4'h9: wake[10:8] <= ee_rd_data[2:0];
        default: wake <= wake;
      endcase
    end else if (wr) begin
      // Software path, taken in any mode in every cycle in which the loader takes no EEPROM byte.
      case (paddr)
        ecs_pkg::OFS_HARDWARE_CONFIG_REG: hardware_config_reg <= {26'h0, pwdata[5:4], 2'b00, pwdata[1:0]};
        ecs_pkg::OFS_LED_CFG: led_cfg <= {31'h0, pwdata[0]};
        ecs_pkg::OFS_WAKE: wake <= {21'h0, pwdata[10:0]};
        ecs_pkg::OFS_ADDR_HI: addr_hi <= {16'h0, pwdata[15:0]};
        ecs_pkg::OFS_ADDR_LO: addr_lo <= pwdata;
        default: addr_lo <= addr_lo;
      endcase
    end
  end

  // Attribute length registers and the marker that they precede RAM writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_len <= ecs_pkg::RESET_WORD;
      fs_len <= ecs_pkg::RESET_WORD;
      str_a <= ecs_pkg::RESET_WORD;
      str_b <= ecs_pkg::RESET_WORD;
      attr_seen <= 1'b0;
    end else if (wr_attr) begin
      attr_seen <= 1'b1;
      case (paddr)
        ecs_pkg::OFS_HS_LEN: hs_len <= {16'h0, pwdata[15:0]};
        ecs_pkg::OFS_FS_LEN: fs_len <= {16'h0, pwdata[15:0]};
        ecs_pkg::OFS_STR_A: str_a <= pwdata;
        default: str_b <= {16'h0, pwdata[15:0]};
      endcase
    end
  end
  // Flag register: loaded from EEPROM, written by software, or updated from the configuration attributes byte written to RAM.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= ecs_pkg::RESET_WORD;
    end else if (ee_take && ld_idx == 4'ha) begin
      flag_reg[ecs_pkg::FLAG_PME_LSB +: 8] <= ee_rd_data;
    end else if (ee_take && ld_idx == 4'hb) begin
      flag_reg[1:0] <= ee_rd_data[1:0];
    end else if (wr_flag) begin
      flag_reg <= {16'h0, pwdata[15:8], 6'h00, pwdata[1:0]};
    end else if (flags_from_ram) begin
      flag_reg[ecs_pkg::FLAG_PWR_BIT] <= attr_byte[ecs_pkg::ATTR_PWR_BIT];
      flag_reg[ecs_pkg::FLAG_RWK_BIT] <= attr_byte[ecs_pkg::ATTR_RWK_BIT];
    end
  end

  // Descriptor RAM data port with auto-incrementing word address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_addr <= 7'h00;
    end else if (wr && paddr == ecs_pkg::OFS_RAM_ADDR) begin
      ram_addr <= pwdata[8:2];
    end else if (wr_ram) begin
      ram_addr <= ram_addr + 7'h01;
    end
  end

  // RAM array write; it holds no reset so it is kept out of the reset process.
  always_ff @(posedge pclk) begin
    if (wr_ram) begin
      ram[ram_addr] <= pwdata;
    end
  end

  // Read mux; the flag register reads zero while the EEPROM owns it, but status still shows flag bits 1:0.
  wire [31:0] status = {26'h0, flag_reg[1:0], attr_seen, (ld_state == ecs_pkg::ECS_DONE),
                        ee_mode, eeprom_present};
  wire [31:0] rd_mux =
      (paddr == ecs_pkg::OFS_STATUS) ? status :
      (paddr == ecs_pkg::OFS_HARDWARE_CONFIG_REG) ? hardware_config_reg :
      (paddr == ecs_pkg::OFS_LED_CFG) ? led_cfg :
      (paddr == ecs_pkg::OFS_WAKE) ? wake :
      (paddr == ecs_pkg::OFS_ADDR_HI) ? addr_hi :
      (paddr == ecs_pkg::OFS_ADDR_LO) ? addr_lo :
      (paddr == ecs_pkg::OFS_HS_LEN) ? hs_len :
      (paddr == ecs_pkg::OFS_FS_LEN) ? fs_len :
      (paddr == ecs_pkg::OFS_STR_A) ? str_a :
      (paddr == ecs_pkg::OFS_STR_B) ? str_b :
      (paddr == ecs_pkg::OFS_FLAG) ? (ee_mode ? 32'h0 : flag_reg) :
      (paddr == ecs_pkg::OFS_RAM_ADDR) ? {23'h0, ram_addr, 2'b00} :
      (paddr == ecs_pkg::OFS_RAM_DATA) ? ram[ram_addr] : 32'h0;

  // Read data captured in the setup cycle, presented during the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata <= hit ? rd_mux : 32'h0;
    end
  end

  // Descriptor read port for the USB device logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_rdata <= 32'h0;
    end else begin
      desc_rdata <= ram[desc_raddr];
    end
  end

  // Single selected source presented to the USB device logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
    end else begin
      cfg.from_ram <= ~ee_mode;
      cfg.station_address_upper <= addr_hi[15:0];
      cfg.station_address_lower <= addr_lo;
      cfg.phy_drive_boost <= hardware_config_reg[ecs_pkg::HW_BOOST_LSB +: 2];
      cfg.led_function_select <= led_cfg[0];
      cfg.pin_wake_enable_bits <= wake[ecs_pkg::WAKE_BITS-1:0];
      cfg.power_source_flag <= flag_reg[ecs_pkg::FLAG_PWR_BIT];
      cfg.remote_wakeup_flag <= flag_reg[ecs_pkg::FLAG_RWK_BIT];
      cfg.pme_flags <= flag_reg[ecs_pkg::FLAG_PME_LSB +: 8];
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_flag;
    setup && !pwrite && paddr == ecs_pkg::OFS_FLAG && ee_mode;
  endsequence
  sequence s_wr_flag_locked;
    wr && paddr == ecs_pkg::OFS_FLAG && ee_mode && !ld_busy;
  endsequence

  AST_LOAD_START: assert property (presetn && ld_state == ecs_pkg::ECS_IDLE && ee_mode |=>
    ld_state == ecs_pkg::ECS_REQ ##1 ee_rd_req) else $error("loader did not start");
  AST_REQ_HOLD: assert property (ee_rd_req && !ee_rd_ack |=>
    ee_rd_req && $stable(ee_rd_addr)) else $error("EEPROM request dropped early");
  AST_TAIL_FREE: assert property (ee_rd_req |->
    ee_rd_addr < ecs_pkg::EE_FREE_START) else $error("loader read host area");
  AST_FLAG_HIDDEN: assert property (s_rd_flag |=> prdata == 32'h0)
    else $error("flag register visible in EEPROM operation");
  AST_FLAG_LOCK: assert property (s_wr_flag_locked |=> $stable(flag_reg))
    else $error("flag register modified in EEPROM operation");
  AST_ORDER: assert property (wr_ram && !attr_seen && !ee_take |=>
    $stable(flag_reg)) else $error("flags updated without prior attribute write");
  AST_RAM_FLAGS: assert property (flags_from_ram && !ee_take |=>
    flag_reg[ecs_pkg::FLAG_PWR_BIT] == $past(attr_byte[ecs_pkg::ATTR_PWR_BIT]) &&
    flag_reg[ecs_pkg::FLAG_RWK_BIT] == $past(attr_byte[ecs_pkg::ATTR_RWK_BIT]))
    else $error("flags not taken from attributes byte");
  AST_SOURCE: assert property (presetn |=> cfg.from_ram == !$past(ee_mode))
    else $error("source select inconsistent");
  AST_RAM_INC: assert property (wr_ram |=> ram_addr == $past(ram_addr) + 7'h01)
    else $error("descriptor address did not advance");
  AST_SLVERR: assert property (acc && !hit |-> pslverr && pready)
    else $error("unmapped access not flagged");

endmodule

// >>> design/ecs_pkg.sv
// Package with constants, field layouts and carrier types of the configuration source block.
package ecs_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_HARDWARE_CONFIG_REG = 8'h04;
  localparam logic [7:0] OFS_LED_CFG = 8'h08;
  localparam logic [7:0] OFS_WAKE = 8'h0c;
  localparam logic [7:0] OFS_ADDR_HI = 8'h10;
  localparam logic [7:0] OFS_ADDR_LO = 8'h14;
  localparam logic [7:0] OFS_HS_LEN = 8'h18;
  localparam logic [7:0] OFS_FS_LEN = 8'h1c;
  localparam logic [7:0] OFS_STR_A = 8'h20;
  localparam logic [7:0] OFS_STR_B = 8'h24;
  localparam logic [7:0] OFS_FLAG = 8'h28;
  localparam logic [7:0] OFS_RAM_ADDR = 8'h2c;
  localparam logic [7:0] OFS_RAM_DATA = 8'h30;

  // ==========================================================================
  // Field positions and reset values.
  localparam int HW_EEM_BIT = 0;
  localparam int HW_PROT_BIT = 1;
  localparam int HW_BOOST_LSB = 4;
  localparam int FLAG_RWK_BIT = 0;
  localparam int FLAG_PWR_BIT = 1;
  localparam int FLAG_PME_LSB = 8;
  localparam int ATTR_PWR_BIT = 6;
  localparam int ATTR_RWK_BIT = 5;
  localparam int WAKE_BITS = 11;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ==========================================================================
  // EEPROM layout used by the loader.
  localparam logic [7:0] EE_ADDR_BASE = 8'h01;
  localparam logic [7:0] EE_BOOST = 8'h07;
  localparam logic [7:0] EE_LED = 8'h08;
  localparam logic [7:0] EE_CFG_FLAGS = 8'h09;
  localparam logic [7:0] EE_WAKE_LO = 8'h1e;
  localparam logic [7:0] EE_WAKE_HI = 8'h1f;
  localparam logic [7:0] EE_PME = 8'h20;
  localparam logic [7:0] EE_FREE_START = 8'h96;
  localparam logic [3:0] EE_ITEMS = 4'hc;
  localparam logic [7:0] EX_ATTRIBUTES = 8'ha0;
  localparam logic [7:0] EX_MAX_POWER = 8'hfa;
  localparam int MAX_POWER_MA = 500;
  localparam int MAX_POWER_UNIT_MA = 2;

  // ==========================================================================
  // Descriptor RAM geometry and attributes byte position in a configuration descriptor.
  localparam int RAM_BYTES = 512;
  localparam int RAM_WORDS = RAM_BYTES / 4;
  localparam logic [9:0] CFG_ATTR_OFS = 10'h007;

  // Loader states, Gray coded along the load path.
  typedef enum logic [1:0] {
    ECS_IDLE = 2'b00,
    ECS_REQ = 2'b01,
    ECS_WAIT = 2'b11,
    ECS_DONE = 2'b10
  } ecs_state_t;

  // Values presented to the USB device logic.
  typedef struct packed {
    logic from_ram;
    logic [15:0] station_address_upper;
    logic [31:0] station_address_lower;
    logic [1:0] phy_drive_boost;
    logic led_function_select;
    logic [10:0] pin_wake_enable_bits;
    logic power_source_flag;
    logic remote_wakeup_flag;
    logic [7:0] pme_flags;
  } ecs_cfg_t;

endpackage

// >>> testbench/ecs_eeprom_model.sv
// EEPROM partner model answering the single byte reads of the loader.
`timescale 1ns/1ps
module ecs_eeprom_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ee_rd_req,
  input wire logic [7:0] ee_rd_addr,
  input wire logic [3:0] slow,
  output logic ee_rd_ack,
  output logic [7:0] ee_rd_data,
  output int hi_reads
);
  logic [7:0] mem [256];
  int cnt;
  // =====================================================================
  // Image tail: attributes and power bytes of both configuration descriptors.
  initial begin
    mem[8'h67] = ecs_pkg::EX_ATTRIBUTES;
    mem[8'h68] = ecs_pkg::EX_MAX_POWER;
    mem[8'h8b] = ecs_pkg::EX_ATTRIBUTES;
    mem[8'h8c] = ecs_pkg::EX_MAX_POWER;
  end
  // Answers after a variable wait; the data line toggles outside the ack cycle.
  // Reads of the free host area are counted, since the loader must never touch it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      ee_rd_ack <= 1'b0;
      ee_rd_data <= 8'h00;
      hi_reads <= 0;
    end else if (ee_rd_req && !ee_rd_ack && cnt >= int'(slow)) begin
      ee_rd_ack <= 1'b1;
      ee_rd_data <= mem[ee_rd_addr];
      cnt <= 0;
      if (ee_rd_addr >= ecs_pkg::EE_FREE_START) begin
        hi_reads <= hi_reads + 1;
      end
    end else begin
      ee_rd_ack <= 1'b0;
      ee_rd_data <= ~ee_rd_data;
      if (ee_rd_req && !ee_rd_ack) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench of the configuration source block.
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, eeprom_present, pready, pslverr, err;
  logic ee_rd_req, ee_rd_ack;
  logic [7:0] paddr, ee_rd_addr, ee_rd_data;
  logic [31:0] pwdata, prdata, rd, desc_rdata, r1, r2, w6;
  logic [6:0] desc_raddr;
  logic [3:0] ee_slow;
  logic [1:0] b;
  logic [10:0] wk;
  logic [7:0] img [64];
  ecs_pkg::ecs_cfg_t cfg, exp_cfg;
  int seed = 70;
  int error_cnt = 0;
  int cmp_count = 0;
  int hi_reads;
  ecs_config_source ecs_config_source_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eeprom_present(eeprom_present),
    .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr), .ee_rd_ack(ee_rd_ack),
    .ee_rd_data(ee_rd_data), .desc_raddr(desc_raddr), .desc_rdata(desc_rdata), .cfg(cfg));
  ecs_eeprom_model ecs_eeprom_model_inst (.pclk(pclk), .presetn(presetn),
    .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr), .slow(ee_slow),
    .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data), .hi_reads(hi_reads));
  // =====================================================================
  // Clock, random EEPROM answer delay and watchdog.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) ee_slow <= 4'($random(seed));
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    print_verdict();
  end
  // =====================================================================
  // Shared tasks.
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One APB transfer; read data and error are taken at the edge that samples pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic do_reset(input logic ee);
    @(posedge pclk);
    presetn <= 1'b0;
    eeprom_present <= ee;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic ram_check(input logic [6:0] idx, input logic [31:0] exp);
    @(posedge pclk);
    desc_raddr <= idx;
    settle();
    check(desc_rdata, exp);
  endtask
  // =====================================================================
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, desc_raddr} = '0;
    eeprom_present = 1'b1;
    for (int i = 0; i < 64; i++) begin
      img[i] = 8'($random(seed));
      ecs_eeprom_model_inst.mem[i] = img[i];
    end
    do_reset(1'b1);
    rd = '0;
    for (int i = 0; i < 200 && rd[2] !== 1'b1; i++) apb(1'b0, ecs_pkg::OFS_STATUS, '0);
    check(rd[3:0], 4'h7);
    settle();
    exp_cfg = {1'b0, img[6], img[5], img[4], img[3], img[2], img[1], img[7][1:0], img[8][0],
      img[31][2:0], img[30], img[9][1], img[9][0], img[32]};
    check(cfg, exp_cfg);
    check(hi_reads, 0);
    apb(1'b1, ecs_pkg::OFS_FLAG, 32'h0000_ffff);
    apb(1'b0, ecs_pkg::OFS_FLAG, '0);
    check(rd, 32'h0);
    settle();
    check(cfg, exp_cfg);
    apb(1'b1, ecs_pkg::OFS_HARDWARE_CONFIG_REG, {26'h0, img[7][1:0], 4'h1});
    settle();
    check(cfg.from_ram, 1'b1);
    $display("test eeprom load done");
    r1 = $random(seed);
    r2 = $random(seed);
    w6 = $random(seed);
    b = 2'($random(seed));
    wk = 11'($random(seed));
    do_reset(1'b0);
    apb(1'b1, ecs_pkg::OFS_ADDR_HI, {16'h0, r1[15:0]});
    apb(1'b1, ecs_pkg::OFS_ADDR_LO, r2);
    apb(1'b1, ecs_pkg::OFS_HARDWARE_CONFIG_REG, {26'h0, b, 4'h0});
    apb(1'b1, ecs_pkg::OFS_LED_CFG, 32'h1);
    apb(1'b1, ecs_pkg::OFS_WAKE, {21'h0, wk});
    // Descriptor data written before any attribute register must leave the flags alone.
    apb(1'b1, ecs_pkg::OFS_RAM_ADDR, 32'd28);
    apb(1'b1, ecs_pkg::OFS_RAM_DATA, 32'h6000_0000);
    apb(1'b0, ecs_pkg::OFS_FLAG, '0);
    check(rd, 32'h0);
    apb(1'b1, ecs_pkg::OFS_FLAG, 32'h0000_8a00);
    apb(1'b1, ecs_pkg::OFS_STR_A, 32'h4);
    apb(1'b1, ecs_pkg::OFS_STR_B, '0);
    apb(1'b1, ecs_pkg::OFS_HS_LEN, 32'h1212);
    apb(1'b1, ecs_pkg::OFS_FS_LEN, '0);
    apb(1'b0, ecs_pkg::OFS_HS_LEN, '0);
    check(rd, 32'h1212);
    // The HS configuration descriptor starts at byte 24, its attributes byte is byte 31.
    apb(1'b1, ecs_pkg::OFS_RAM_ADDR, 32'd24);
    apb(1'b1, ecs_pkg::OFS_RAM_DATA, w6);
    apb(1'b1, ecs_pkg::OFS_RAM_DATA, {8'ha0, r1[23:0]});
    apb(1'b0, ecs_pkg::OFS_FLAG, '0);
    check(rd, 32'h0000_8a01);
    ram_check(7'd6, w6);
    ram_check(7'd7, {8'ha0, r1[23:0]});
    apb(1'b1, ecs_pkg::OFS_RAM_ADDR, 32'h1fc);
    apb(1'b1, ecs_pkg::OFS_RAM_DATA, r1 ^ r2);
    ram_check(7'd127, r1 ^ r2);
    apb(1'b1, ecs_pkg::OFS_HARDWARE_CONFIG_REG, {26'h0, b, 4'h3});
    settle();
    exp_cfg = {1'b1, r1[15:0], r2, b, 1'b1, wk, 1'b0, 1'b1, 8'h8a};
    check(cfg, exp_cfg);
    foreach (img[i]) begin
      if (i < 2) begin
        apb(1'b0, (i == 0) ? 8'h34 : 8'h02, '0);
        check({err, rd}, {1'b1, 32'h0});
      end
    end
    $display("test register source done");
    print_verdict();
  end
endmodule
